// File: asp_pkg.sv
package asp_pkg;
    // Register byte offsets
    localparam logic [7:0] ADR_DATA = 8'h00;
    localparam logic [7:0] ADR_FLAG = 8'h04;
    localparam logic [7:0] ADR_IBRD = 8'h08;
    localparam logic [7:0] ADR_FBRD = 8'h0C;
    localparam logic [7:0] ADR_LCR  = 8'h10;
    localparam logic [7:0] ADR_CTL  = 8'h14;
    localparam logic [7:0] ADR_ILPR = 8'h18;
    // line_control_reg fields
    localparam int LCR_BRK  = 0;
    localparam int LCR_PEN  = 1;
    localparam int LCR_EPS  = 2;
    localparam int LCR_STP2 = 3;
    localparam int LCR_FEN  = 4;
    localparam int LCR_WLEN = 5;
    localparam int LCR_SPS  = 7;
    // control_reg fields
    localparam int CTL_EN   = 0;
    localparam int CTL_SIR  = 1;
    localparam int CTL_SIRLP = 2;
    localparam int CTL_LBE  = 7;
    localparam int CTL_TXE  = 8;
    localparam int CTL_RXE  = 9;
    // flag_reg fields
    localparam int FR_BUSY  = 3;
    localparam int FR_RXFE  = 4;
    localparam int FR_TXFF  = 5;
    localparam int FR_RXFF  = 6;
    localparam int FR_TXFE  = 7;
    // Receive entry status bits
    localparam int ERR_FE   = 8;
    localparam int ERR_PE   = 9;
    localparam int ERR_BE   = 10;
    localparam int ERR_OE   = 11;
    // Reset values
    localparam logic [9:0]  CTL_RESET  = 10'h300;
    localparam logic [7:0]  LCR_RESET  = 8'h00;
    localparam logic [15:0] IBRD_RESET = 16'h0000;
    localparam logic [5:0]  FBRD_RESET = 6'h00;
    localparam logic [7:0]  ILPR_RESET = 8'h00;
    // Oversample timing
    localparam logic [3:0] SUB_LAST  = 4'hF;
    localparam logic [3:0] SUB_START = 4'h7;
    localparam logic [3:0] IR_PULSE  = 4'h3;
    localparam logic [1:0] LP_PULSE  = 2'h3;
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
        TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
    } asp_tx_type;
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
        RX_PAR  = 5'b01000, RX_STOP  = 5'b10000
    } asp_rx_type;
endpackage

// File: asp_remote.sv
`timescale 1ns/10ps
module asp_remote #(
    parameter int BIT = 16
) (
    // Clock
    input  wire logic       mclk,
    // Serial line
    input  wire logic       line_in,
    output logic            line_out,
    // Received data with the bit after it (stop, or parity when enabled)
    output logic [8:0]      got,
    output logic            got_stb
);
    initial begin
        line_out = 1'b1;
        got = 9'h000;
        got_stb = 1'b0;
    end
    // Mid-bit sampling; eight data bits and the one bit after them only (stop, or parity when enabled)
    always begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge mclk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge mclk);
            got[i] = line_in;
        end
        got_stb <= 1'b1;
        @(posedge mclk);
        got_stb <= 1'b0;
    end
    // Stop at the given level, then idle high so the receiver re-arms
    task automatic send(input logic [7:0] d, input logic stp);
        logic [10:0] f;
        f = {1'b1, stp, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_out <= f[i];
            repeat (BIT) @(posedge mclk);
        end
    endtask
    // Too short to survive the mid-start check
    task automatic glitch;
        line_out <= 1'b0;
        repeat (4) @(posedge mclk);
        line_out <= 1'b1;
        repeat (40) @(posedge mclk);
    endtask
endmodule

// File: asp_top.sv
`timescale 1ns/10ps
// How it works
// - Separate 16-character transmit and receive FIFOs; receive entries carry four status bits.
// - FIFO depth selectable, including single-entry double-buffered holding register mode.
// - Character length programmable to 5, 6, 7 or 8 data bits.
// - Parity even, odd, stick or none, for both transmit and receive.
// - Transmitter appends one or two stop bits as programmed.
// - Line break can be sent and is detected on input.
// - Transmit and receive have own enable bits, both set after reset.
// - Disabling the port mid-character finishes that character first.
// - Frame is start bit, data LSB first, optional parity, stop bits.
// - Overrun, parity, framing and break flags stored with each received character.
// - Divisor is 16-bit integer plus 6-bit fraction, 22 bits total.
// - Oversample tick at sixteen times bit rate drives transmit and receive.
// - Divisor and line settings load together only on line control write.
// - With port and transmit enabled, writing transmit FIFO starts sending until the FIFO is empty.
// - Busy rises on non-empty FIFO, falls after last stop bit leaves.
// - Start bit accepted only if input still low on eighth tick.
// - Data bits sampled every sixteenth tick after the start bit.
// - Parity bit sampled and checked right after the last data bit.
// - Stop sampled low flags framing error; character still stored.
// - Infrared coding selectable, low-power divider from 1 to 256.
// - Normal infrared sends zero as 3/16 bit high pulse, one as low.
// - Low-power infrared pulse lasts three low-power ticks.
// - After reset both FIFOs act as single-entry holding registers.
// - Loopback routes the transmit stream into the receiver.
module asp_top
    import asp_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Serial line
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin
);
    localparam int CW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("DEPTH must be a power of two of at least 2");
    end

    function automatic logic par_of(input logic [7:0] d, input logic [7:0] l);
        logic [7:0] m;
        m = d & (8'hFF >> (2'd3 - l[LCR_WLEN +: 2]));
        if (l[LCR_SPS]) begin
            par_of = ~l[LCR_EPS];
        end else begin
            par_of = l[LCR_EPS] ? ^m : ~^m;
        end
    endfunction

    // Bus slave: one wait state so read data leaves a flop
    logic        pend_q, pend_d, wr_q, wr_d, rdy_q, rdy_d;
    logic [7:0]  adr_q, adr_d;
    logic [31:0] rd_q, rd_d, rd_val;
    logic        take;
    logic        wr_data, wr_ibrd, wr_fbrd, wr_lcr, wr_ctl, wr_ilpr, rd_data;
    // Configuration
    logic [15:0] ibrd_q, ibrd_d, sh_ibrd_q, sh_ibrd_d;
    logic [5:0]  fbrd_q, fbrd_d, sh_fbrd_q, sh_fbrd_d;
    logic [7:0]  lcr_q, lcr_d, ilpr_q, ilpr_d;
    logic [9:0]  ctl_q, ctl_d;
    // Tick generators
    logic [15:0] bcnt_q, bcnt_d;
    logic [5:0]  acc_q, acc_d;
    logic [7:0]  lpc_q, lpc_d;
    logic        tick, lptick, carry;
    // FIFOs
    logic [7:0]  tx_mem [DEPTH];
    logic [11:0] rx_mem [DEPTH];
    logic [CW-1:0] txw_q, txw_d, txr_q, txr_d, rxw_q, rxw_d, rxr_q, rxr_d;
    logic [CW:0] txc_q, txc_d, rxc_q, rxc_d, cap;
    logic        tx_push, tx_pop, rx_push, rx_pop, tx_full, rx_full;
    logic [11:0] rx_wd;
    // Transmitter
    asp_tx_type  tst_q, tst_d;
    logic [7:0]  tsh_q, tsh_d;
    logic [2:0]  tbit_q, tbit_d, nlast;
    logic [3:0]  tsub_q, tsub_d;
    logic [1:0]  lpn_q, lpn_d;
    logic        tpar_q, tpar_d, tstp_q, tstp_d, raw_q, raw_d, out_q, out_d;
    logic        busy_q, busy_d, tend;
    // Receiver
    asp_rx_type  rst_q, rst_d;
    logic [7:0]  rsh_q, rsh_d;
    logic [2:0]  rbit_q, rbit_d;
    logic [3:0]  rsub_q, rsub_d, irs_q, irs_d;
    logic        rprev_q, rprev_d, perr_q, perr_d, allz_q, allz_d;
    logic        ovp_q, ovp_d, line, rsmp;

    assign take    = hsel && htrans[1] && hready;
    assign wr_data = pend_q && wr_q && adr_q == ADR_DATA;
    assign wr_ibrd = pend_q && wr_q && adr_q == ADR_IBRD;
    assign wr_fbrd = pend_q && wr_q && adr_q == ADR_FBRD;
    assign wr_lcr  = pend_q && wr_q && adr_q == ADR_LCR;
    assign wr_ctl  = pend_q && wr_q && adr_q == ADR_CTL;
    assign wr_ilpr = pend_q && wr_q && adr_q == ADR_ILPR;
    assign rd_data = pend_q && !wr_q && adr_q == ADR_DATA;

    always_comb begin
        rd_val = 32'h0000_0000;
        case (adr_q)
            ADR_DATA: rd_val[11:0] = rx_mem[rxr_q];
            ADR_FLAG: begin
                rd_val[FR_BUSY] = busy_q;
                rd_val[FR_RXFE] = rxc_q == 0;
                rd_val[FR_TXFF] = tx_full;
                rd_val[FR_RXFF] = rx_full;
                rd_val[FR_TXFE] = txc_q == 0;
            end
            ADR_IBRD: rd_val[15:0] = ibrd_q;
            ADR_FBRD: rd_val[5:0] = fbrd_q;
            ADR_LCR:  rd_val[7:0] = lcr_q;
            ADR_CTL:  rd_val[9:0] = ctl_q;
            ADR_ILPR: rd_val[7:0] = ilpr_q;
            default:  rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        pend_d = 1'b0;
        wr_d   = wr_q;
        adr_d  = adr_q;
        rdy_d  = 1'b1;
        rd_d   = rd_q;
        if (take) begin
            pend_d = 1'b1;
            wr_d   = hwrite;
            adr_d  = haddr[7:0];
            rdy_d  = 1'b0;
        end else if (pend_q && !wr_q) begin
            rd_d = rd_val;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
            wr_q   <= 1'b0;
            adr_q  <= 8'h00;
            rdy_q  <= 1'b1;
            rd_q   <= 32'h0000_0000;
        end else begin
            pend_q <= pend_d;
            wr_q   <= wr_d;
            adr_q  <= adr_d;
            rdy_q  <= rdy_d;
            rd_q   <= rd_d;
        end
    end

    assign hreadyout = rdy_q;
    assign hrdata    = rd_q;
    assign hresp     = 1'b0;

    // Divisors are staged; live copy moves only with the line settings
    always_comb begin
        ibrd_d    = wr_ibrd ? hwdata[15:0] : ibrd_q;
        fbrd_d    = wr_fbrd ? hwdata[5:0] : fbrd_q;
        lcr_d     = wr_lcr ? hwdata[7:0] : lcr_q;
        sh_ibrd_d = wr_lcr ? ibrd_q : sh_ibrd_q;
        sh_fbrd_d = wr_lcr ? fbrd_q : sh_fbrd_q;
        ctl_d     = wr_ctl ? hwdata[9:0] : ctl_q;
        ilpr_d    = wr_ilpr ? hwdata[7:0] : ilpr_q;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ibrd_q    <= IBRD_RESET;
            fbrd_q    <= FBRD_RESET;
            sh_ibrd_q <= IBRD_RESET;
            sh_fbrd_q <= FBRD_RESET;
            lcr_q     <= LCR_RESET;
            ctl_q     <= CTL_RESET;
            ilpr_q    <= ILPR_RESET;
        end else begin
            ibrd_q    <= ibrd_d;
            fbrd_q    <= fbrd_d;
            sh_ibrd_q <= sh_ibrd_d;
            sh_fbrd_q <= sh_fbrd_d;
            lcr_q     <= lcr_d;
            ctl_q     <= ctl_d;
            ilpr_q    <= ilpr_d;
        end
    end

    // Fraction accumulator stretches one period by a cycle on overflow
    assign tick   = bcnt_q == 16'h0000 && sh_ibrd_q != 16'h0000;
    assign lptick = lpc_q == 8'h00;
    always_comb begin
        {carry, acc_d} = {1'b0, acc_q};
        bcnt_d = bcnt_q - 16'h0001;
        if (sh_ibrd_q == 16'h0000) begin
            bcnt_d = 16'h0000;
        end else if (tick) begin
            {carry, acc_d} = {1'b0, acc_q} + {1'b0, sh_fbrd_q};
            bcnt_d = sh_ibrd_q - 16'h0001 + {15'h0000, carry};
        end
        lpc_d = lptick ? ilpr_q - 8'h01 : lpc_q - 8'h01;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bcnt_q <= 16'h0000;
            acc_q  <= 6'h00;
            lpc_q  <= 8'h00;
        end else begin
            bcnt_q <= bcnt_d;
            acc_q  <= acc_d;
            lpc_q  <= lpc_d;
        end
    end

    // FIFO bookkeeping; a full push is dropped
    assign cap     = lcr_q[LCR_FEN] ? (CW+1)'(DEPTH) : (CW+1)'(1);
    assign tx_full = txc_q >= cap;
    assign rx_full = rxc_q >= cap;
    assign tx_push = wr_data && !tx_full;
    assign rx_pop  = rd_data && rxc_q != 0;
    always_comb begin
        txw_d = tx_push ? txw_q + 1'b1 : txw_q;
        txr_d = tx_pop ? txr_q + 1'b1 : txr_q;
        txc_d = txc_q + (CW+1)'(tx_push) - (CW+1)'(tx_pop);
        rxw_d = (rx_push && !rx_full) ? rxw_q + 1'b1 : rxw_q;
        rxr_d = rx_pop ? rxr_q + 1'b1 : rxr_q;
        rxc_d = rxc_q + (CW+1)'(rx_push && !rx_full) - (CW+1)'(rx_pop);
    end

    always_ff @(posedge mclk) begin
        if (tx_push) begin
            tx_mem[txw_q] <= hwdata[7:0];
        end
        if (rx_push && !rx_full) begin
            rx_mem[rxw_q] <= rx_wd;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            txw_q <= '0;
            txr_q <= '0;
            txc_q <= '0;
            rxw_q <= '0;
            rxr_q <= '0;
            rxc_q <= '0;
        end else begin
            txw_q <= txw_d;
            txr_q <= txr_d;
            txc_q <= txc_d;
            rxw_q <= rxw_d;
            rxr_q <= rxr_d;
            rxc_q <= rxc_d;
        end
    end

    // Transmitter
    assign nlast  = {1'b1, lcr_q[LCR_WLEN +: 2]};
    assign tend   = tick && tsub_q == SUB_LAST;
    assign tx_pop = tst_q == TX_IDLE && txc_q != 0 && ctl_q[CTL_EN] && ctl_q[CTL_TXE];
    always_comb begin
        tst_d  = tst_q;
        tsh_d  = tsh_q;
        tbit_d = tbit_q;
        tpar_d = tpar_q;
        tstp_d = tstp_q;
        tsub_d = tick ? tsub_q + 4'h1 : tsub_q;
        case (tst_q)
            TX_IDLE: if (tx_pop) begin
                tst_d  = TX_START;
                tsh_d  = tx_mem[txr_q];
                tpar_d = par_of(tx_mem[txr_q], lcr_q);
                tsub_d = 4'h0;
            end
            TX_START: if (tend) begin
                tst_d  = TX_DATA;
                tbit_d = 3'd0;
            end
            TX_DATA: if (tend) begin
                tsh_d  = tsh_q >> 1;
                tbit_d = tbit_q + 3'd1;
                tstp_d = 1'b0;
                if (tbit_q == nlast) begin
                    tst_d = lcr_q[LCR_PEN] ? TX_PAR : TX_STOP;
                end
            end
            TX_PAR: if (tend) begin
                tst_d = TX_STOP;
            end
            TX_STOP: if (tend) begin
                tstp_d = 1'b1;
                if (!lcr_q[LCR_STP2] || tstp_q) begin
                    tst_d = TX_IDLE;
                end
            end
            default: tst_d = TX_IDLE;
        endcase
        case (tst_q)
            TX_START: raw_d = 1'b0;
            TX_DATA:  raw_d = tsh_q[0];
            TX_PAR:   raw_d = tpar_q;
            default:  raw_d = 1'b1;
        endcase
        if (lcr_q[LCR_BRK]) begin
            raw_d = 1'b0;
        end
        lpn_d = lpn_q;
        if (tsub_d != tsub_q || tx_pop) begin
            lpn_d = 2'd0;
        end else if (lptick && lpn_q != LP_PULSE) begin
            lpn_d = lpn_q + 2'd1;
        end
        if (!ctl_q[CTL_SIR]) begin
            out_d = raw_q;
        end else if (ctl_q[CTL_SIRLP]) begin
            out_d = !raw_q && lpn_q != LP_PULSE;
        end else begin
            out_d = !raw_q && tsub_q < IR_PULSE;
        end
        busy_d = txc_d != 0 || tst_d != TX_IDLE;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tst_q  <= TX_IDLE;
            tsh_q  <= 8'h00;
            tbit_q <= 3'd0;
            tsub_q <= 4'h0;
            tpar_q <= 1'b0;
            tstp_q <= 1'b0;
            lpn_q  <= 2'd0;
            raw_q  <= 1'b1;
            out_q  <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            tst_q  <= tst_d;
            tsh_q  <= tsh_d;
            tbit_q <= tbit_d;
            tsub_q <= tsub_d;
            tpar_q <= tpar_d;
            tstp_q <= tstp_d;
            lpn_q  <= lpn_d;
            raw_q  <= raw_d;
            out_q  <= out_d;
            busy_q <= busy_d;
        end
    end

    assign serial_out_pin = out_q;

    // Receiver; infrared pulses are stretched to about one bit
    always_comb begin
        if (ctl_q[CTL_LBE]) begin
            line = raw_q;
        end else if (ctl_q[CTL_SIR]) begin
            line = serial_in_pin && irs_q == 4'h0;
        end else begin
            line = serial_in_pin;
        end
    end
    assign rsmp = tick && rsub_q == SUB_LAST;

    always_comb begin
        rst_d   = rst_q;
        rsh_d   = rsh_q;
        rbit_d  = rbit_q;
        perr_d  = perr_q;
        allz_d  = allz_q;
        rx_push = 1'b0;
        rx_wd   = 12'h000;
        rprev_d = line;
        irs_d   = !serial_in_pin ? SUB_LAST : (tick && irs_q != 0 ? irs_q - 4'h1 : irs_q);
        rsub_d  = tick ? rsub_q + 4'h1 : rsub_q;
        case (rst_q)
            RX_IDLE: if (rprev_q && !line && ctl_q[CTL_EN] && ctl_q[CTL_RXE]) begin
                rst_d  = RX_START;
                rsub_d = 4'h0;
                rsh_d  = 8'h00;
                rbit_d = 3'd0;
                perr_d = 1'b0;
                allz_d = 1'b1;
            end
            RX_START: if (tick && rsub_q == SUB_START) begin
                rst_d  = line ? RX_IDLE : RX_DATA;
                rsub_d = 4'h0;
            end
            RX_DATA: if (rsmp) begin
                rsh_d[rbit_q] = line;
                allz_d = allz_q && !line;
                rbit_d = rbit_q + 3'd1;
                if (rbit_q == nlast) begin
                    rst_d = lcr_q[LCR_PEN] ? RX_PAR : RX_STOP;
                end
            end
            RX_PAR: if (rsmp) begin
                perr_d = line != par_of(rsh_q, lcr_q);
                allz_d = allz_q && !line;
                rst_d  = RX_STOP;
            end
            RX_STOP: if (rsmp) begin
                rx_push = 1'b1;
                rx_wd[ERR_FE] = !line;
                rx_wd[ERR_BE] = allz_q && !line;
                rx_wd[ERR_PE] = perr_q;
                rx_wd[ERR_OE] = ovp_q;
                rx_wd[7:0] = (allz_q && !line) ? 8'h00 : rsh_q;
                rst_d = RX_IDLE;
            end
            default: rst_d = RX_IDLE;
        endcase
        // Lost character marks the next stored one
        ovp_d = rx_push ? rx_full : ovp_q;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_q   <= RX_IDLE;
            rsh_q   <= 8'h00;
            rbit_q  <= 3'd0;
            rsub_q  <= 4'h0;
            irs_q   <= 4'h0;
            rprev_q <= 1'b1;
            perr_q  <= 1'b0;
            allz_q  <= 1'b0;
            ovp_q   <= 1'b0;
        end else begin
            rst_q   <= rst_d;
            rsh_q   <= rsh_d;
            rbit_q  <= rbit_d;
            rsub_q  <= rsub_d;
            irs_q   <= irs_d;
            rprev_q <= rprev_d;
            perr_q  <= perr_d;
            allz_q  <= allz_d;
            ovp_q   <= ovp_d;
        end
    end

    // Checks
    sequence s_start_seen;
        rst_q == RX_START && tick && rsub_q == SUB_START;
    endsequence

    AST_RESET_EN: assert property (@(posedge mclk) $fell(sys_rst) |-> ctl_q[9:8] == 2'b11)
        else $error("enables not set after reset");
    AST_START_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
        tst_q == TX_START && !lcr_q[LCR_BRK] |=> !raw_q)
        else $error("start bit not low");
    AST_BUSY: assert property (@(posedge mclk) disable iff (sys_rst)
        txc_q != 0 |-> busy_q)
        else $error("busy low with data queued");
    AST_STOP_CNT: assert property (@(posedge mclk) disable iff (sys_rst)
        tst_q == TX_STOP && tend && !tstp_q && lcr_q[LCR_STP2] |=> tst_q == TX_STOP)
        else $error("second stop bit skipped");
    AST_START_REJ: assert property (@(posedge mclk) disable iff (sys_rst)
        s_start_seen and line |=> rst_q == RX_IDLE)
        else $error("false start accepted");
    AST_START_OK: assert property (@(posedge mclk) disable iff (sys_rst)
        s_start_seen and !line |=> rst_q == RX_DATA && rsub_q == 4'h0)
        else $error("valid start not taken");
    // A pop in the same cycle takes one back off the count
    AST_FRAME: assert property (@(posedge mclk) disable iff (sys_rst)
        rst_q == RX_STOP && rsmp && !line && !rx_full
        |=> rxc_q == $past(rxc_q) + 1'b1 - $past(rx_pop))
        else $error("framed character not stored");
    AST_SHADOW: assert property (@(posedge mclk) disable iff (sys_rst)
        !wr_lcr |=> $stable(sh_ibrd_q) && $stable(sh_fbrd_q))
        else $error("divisor moved without line write");
    AST_TICK_GAP: assert property (@(posedge mclk) disable iff (sys_rst)
        tick && sh_ibrd_q > 16'h0002 && !wr_lcr |=> !tick [*2])
        else $error("tick period too short");
    AST_DEPTH1: assert property (@(posedge mclk) disable iff (sys_rst)
        !lcr_q[LCR_FEN] && !wr_lcr |-> txc_q <= 1 && rxc_q <= 1)
        else $error("single-entry mode overfilled");
endmodule

// File: tb_async_serial_port.sv
`timescale 1ns/10ps
`define CHK(a, e) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        fails++; \
        $display("ERROR at %0t: got %h expected %h", $time, a, e); \
    end \
end
module tb_async_serial_port
    import asp_pkg::*;
;
    logic        mclk;
    logic        sys_rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        rx_line;
    logic        tx_line;
    logic [8:0]  got;
    logic        got_stb;
    int          fails;
    int          cmp_count;
    logic [31:0] rd_q[$];
    logic [8:0]  tx_q[$];
    logic [31:0] rexp;
    logic [8:0]  texp;
    logic [7:0]  rb[2];
    event        rd_ev;

    asp_top #(.DEPTH(16)) i_asp_top (
        .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .serial_in_pin(rx_line), .serial_out_pin(tx_line));
    asp_remote i_asp_remote (
        .mclk(mclk), .line_in(tx_line), .line_out(rx_line),
        .got(got), .got_stb(got_stb));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            end_of_test();
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        xfer(a, 1'b0, 32'h0000_0000);
        -> rd_ev;
    endtask

    task automatic drain;
        for (int n = 0; n < 3000 && tx_q.size() > 0; n++) @(posedge mclk);
        if (tx_q.size() > 0) begin
            fails++;
            end_of_test();
        end
        repeat (40) @(posedge mclk);
    endtask

    always @(rd_ev) begin
        rexp = rd_q.pop_front();
        `CHK(hrdata, rexp)
    end

    always @(posedge mclk) begin
        if (got_stb === 1'b1) begin
            texp = tx_q.pop_front();
            `CHK(got, texp)
        end
    end

    initial begin
        sys_rst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        fails = 0;
        cmp_count = 0;
        void'($urandom(72));
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(ADR_CTL, 32'h0000_0300);
        rd(ADR_FLAG, 32'h0000_0090);
        rd(8'h40, 32'h0000_0000);
        // Divisor 3.5 runs the fraction carry while the port is off
        xfer(ADR_IBRD, 1'b1, 32'h0000_0003);
        xfer(ADR_FBRD, 1'b1, 32'h0000_0020);
        xfer(ADR_LCR, 1'b1, 32'h0000_0070);
        rd(ADR_IBRD, 32'h0000_0003);
        rd(ADR_FBRD, 32'h0000_0020);
        xfer(ADR_IBRD, 1'b1, 32'h0000_0001);
        xfer(ADR_FBRD, 1'b1, 32'h0000_0000);
        xfer(ADR_LCR, 1'b1, 32'h0000_0070);
        xfer(ADR_CTL, 1'b1, 32'h0000_0301);
        for (int i = 0; i < 4; i++) begin
            rb[0] = 8'($urandom_range(255));
            tx_q.push_back({1'b1, rb[0]});
            xfer(ADR_DATA, 1'b1, {24'h00_0000, rb[0]});
        end
        rd(ADR_FLAG, 32'h0000_0018);
        drain();
        rd(ADR_FLAG, 32'h0000_0090);
        for (int i = 0; i < 2; i++) begin
            rb[i] = 8'($urandom_range(255));
            i_asp_remote.send(rb[i], 1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            rd(ADR_DATA, {24'h00_0000, rb[i]});
        end
        i_asp_remote.send(8'hA5, 1'b0);
        rd(ADR_DATA, 32'h0000_01A5);
        i_asp_remote.send(8'h00, 1'b0);
        rd(ADR_DATA, 32'h0000_0500);
        i_asp_remote.glitch();
        rd(ADR_FLAG, 32'h0000_0090);
        tx_q.push_back(9'h13C);
        xfer(ADR_DATA, 1'b1, 32'h0000_003C);
        xfer(ADR_CTL, 1'b1, 32'h0000_0300);
        rd(ADR_FLAG, 32'h0000_0098);
        drain();
        rd(ADR_FLAG, 32'h0000_0090);
        // Single entry: second character is lost, third carries overrun
        xfer(ADR_LCR, 1'b1, 32'h0000_0060);
        xfer(ADR_CTL, 1'b1, 32'h0000_0301);
        i_asp_remote.send(8'h11, 1'b1);
        i_asp_remote.send(8'h22, 1'b1);
        rd(ADR_DATA, 32'h0000_0011);
        i_asp_remote.send(8'h33, 1'b1);
        rd(ADR_DATA, 32'h0000_0833);
        // Even parity through loopback
        xfer(ADR_CTL, 1'b1, 32'h0000_0300);
        xfer(ADR_LCR, 1'b1, 32'h0000_0076);
        xfer(ADR_CTL, 1'b1, 32'h0000_0381);
        rb[0] = 8'($urandom_range(255));
        tx_q.push_back({^rb[0], rb[0]});
        xfer(ADR_DATA, 1'b1, {24'h00_0000, rb[0]});
        drain();
        rd(ADR_DATA, {24'h00_0000, rb[0]});
        end_of_test();
    end
endmodule
